// *** pkg/tprsm_pkg.sv ***
// Constants, types and register map for the timer routing and port S mux
package tprsm_pkg;

  // Register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_ROUTING = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PS_DATA = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_PS_DIR = 4'h2;
  localparam logic [DATA_W-1:0] RESET_ROUTING = 8'h00;
  localparam logic [DATA_W-1:0] RESET_PS_DATA = 8'h00;
  localparam logic [DATA_W-1:0] RESET_PS_DIR = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // Routing field positions
  localparam int RT_T0CH7_LSB = 6;
  localparam int RT_T0CH5_BIT = 5;
  localparam int RT_T0CH4_BIT = 4;
  localparam int RT_T0CH6_LSB = 2;
  localparam int RT_T1CH7_BIT = 1;
  localparam int RT_T1CH6_BIT = 0;
  localparam logic [1:0] RT_CODE_R = 2'h1;
  localparam logic [1:0] RT_CODE_V = 2'h2;

  // Channel order: t0ch7, t0ch6, t0ch5, t0ch4, t1ch7, t1ch6
  localparam int CH_NUM = 6;
  localparam int CH_T0CH7 = 0;
  localparam int CH_T0CH6 = 1;
  localparam int CH_T0CH5 = 2;
  localparam int CH_T0CH4 = 3;
  localparam int CH_T1CH7 = 4;
  localparam int CH_T1CH6 = 5;
  localparam int CH_T_PIN [CH_NUM] = '{7, 6, 5, 4, 3, 2};
  localparam int CH_R_PIN [CH_NUM] = '{1, 0, 0, 0, 3, 2};
  localparam int CH_V_PIN [CH_NUM] = '{6, 4, 2, 0, 0, 0};

  // Port S pin positions
  localparam int PS_SS = 7;
  localparam int PS_SCK = 6;
  localparam int PS_MOSI = 5;
  localparam int PS_MISO = 4;
  localparam int PS_CAN_TX = 3;
  localparam int PS_CAN_RX = 2;
  localparam int PS_SER_TX = 1;
  localparam int PS_SER_RX = 0;

  // Level handed to a peripheral input that does not own its pin
  localparam logic IDLE_LEVEL = 1'b1;

  typedef enum {
    TPRSM_PIN_T,
    TPRSM_PIN_R,
    TPRSM_PIN_V
  } tprsm_pin_e;

  // One output function: value and output enable
  typedef struct packed {
    logic value;
    logic oe;
  } tprsm_drive_s;

  // Timer channel towards the pins
  typedef struct packed {
    logic compareValue;
    logic compareEnable;
  } tprsm_timer_s;

endpackage

// *** hw/tprsm_pin_cell.sv ***
// Fixed-priority owner select for one port S pin
`timescale 1ns/100ps
module tprsm_pin_cell
(
  input wire logic [2:0] funcOwn,
  input wire tprsm_pkg::tprsm_drive_s [2:0] funcDrive,
  input wire logic dataBit,
  input wire logic dirBit,
  output logic pinOut,
  output logic pinOe,
  output logic gpioOwned
);

  // Bit 2 is the highest priority function
  always_comb
  begin
    pinOut = dataBit;
    pinOe = dirBit;
    gpioOwned = 1'b0;
    if (funcOwn[2])
    begin
      pinOut = funcDrive[2].value;
      pinOe = funcDrive[2].oe;
    end
    else if (funcOwn[1])
    begin
      pinOut = funcDrive[1].value;
      pinOe = funcDrive[1].oe;
    end
    else if (funcOwn[0])
    begin
      pinOut = funcDrive[0].value;
      pinOe = funcDrive[0].oe;
    end
    else
    begin
      // General purpose: data bit out, direction bit as enable
      gpioOwned = 1'b1;
    end
  end

endmodule

// *** hw/tprsm_mux.sv ***
// Timer channel routing and port S pin multiplexer with register port
`timescale 1ns/100ps
// Summary of operation
// - Bits 7..6 place timer0 channel7: T7//V6
// - Bit 5 moves timer0 channel5 T5 to V2
// - Bit 4 moves timer0 channel4 T4 to V0
// - Bits 3..2 place timer0 channel6: T6/R0/V4
// - Bit 1 moves timer1 channel7 T3 to
// - Bit 0 moves timer1 channel6 T2 to
// - Free output pin drives its data bit
// - Data read: register if output, else pin
// - Pin 7: select, two-wire data, pwm_channel_3, GPIO
// - Pin 6: serial clock, pwm_channel_2, then GPIO
// - Pin 5: master out, pwm_channel_1, then GPIO
// - Pin 4: master in, two-wire clock, pwm_channel_0
// - Pins 3,2 carry CAN when enabled
// - Pin 1: async transmit, pwm_channel_7, then GPIO
// - Pin 0: async receive, pwm_channel_6, then GPIO
// - Direction bit sets output unless overridden
module tprsm_mux
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [tprsm_pkg::ADDR_W-1:0] busAddr,
  input wire logic [tprsm_pkg::DATA_W-1:0] busWriteData,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [tprsm_pkg::DATA_W-1:0] busReadData,
  input wire tprsm_pkg::tprsm_timer_s [tprsm_pkg::CH_NUM-1:0] timerChannel,
  output logic [tprsm_pkg::CH_NUM-1:0] timerCaptureIn,
  input wire logic [7:0] portTIn,
  output logic [7:0] portTTimerOut,
  output logic [7:0] portTTimerOe,
  output logic [7:0] portTTimerOwned,
  input wire logic [3:0] portRIn,
  output logic [3:0] portRTimerOut,
  output logic [3:0] portRTimerOe,
  output logic [3:0] portRTimerOwned,
  input wire logic [7:0] portVIn,
  output logic [7:0] portVTimerOut,
  output logic [7:0] portVTimerOe,
  output logic [7:0] portVTimerOwned,
  input wire logic spiEnable,
  input wire tprsm_pkg::tprsm_drive_s spiSs,
  input wire tprsm_pkg::tprsm_drive_s spiSck,
  input wire tprsm_pkg::tprsm_drive_s spiMosi,
  input wire tprsm_pkg::tprsm_drive_s spiMiso,
  output logic [3:0] spiPinIn,
  input wire logic twoWireEnable,
  input wire logic twoWireSdaLow,
  input wire logic twoWireSclLow,
  output logic twoWireSdaIn,
  output logic twoWireSclIn,
  input wire logic [7:0] pwmEnable,
  input wire logic [7:0] pwmOut,
  input wire logic canEnable,
  input wire logic canTx,
  output logic canRx,
  input wire logic asyncSerialTxEnable,
  input wire logic asyncSerialRxEnable,
  input wire logic asyncSerialTx,
  output logic asyncSerialRx,
  input wire logic [7:0] portSIn,
  output logic [7:0] portSOut,
  output logic [7:0] portSOe,
  output logic [7:0] portSGpio
);

  logic [7:0] timerChannelRouting;
  logic [7:0] portSPinData;
  logic [7:0] portSDirection;
  logic [7:0] next_busReadData;
  tprsm_pkg::tprsm_pin_e chanSel [tprsm_pkg::CH_NUM];
  logic [2:0] pinOwn [8];
  tprsm_pkg::tprsm_drive_s [2:0] pinDrive [8];
  logic twoWireOwnsPins;

  // Decode of the routing register for one channel
  function automatic tprsm_pkg::tprsm_pin_e routeSel(input int ch, input logic [7:0] r);
    tprsm_pkg::tprsm_pin_e sel;
    logic [1:0] code;
    sel = tprsm_pkg::TPRSM_PIN_T;
    code = 2'h0;
    case (ch)
      tprsm_pkg::CH_T0CH7:
      begin
        code = r[tprsm_pkg::RT_T0CH7_LSB +: 2];
      end
      tprsm_pkg::CH_T0CH6:
      begin
        code = r[tprsm_pkg::RT_T0CH6_LSB +: 2];
      end
      default:
      begin
        code = 2'h0;
      end
    endcase
    case (ch)
      tprsm_pkg::CH_T0CH7, tprsm_pkg::CH_T0CH6:
      begin
        // Reserved code falls back to the port T pin
        if (code == tprsm_pkg::RT_CODE_R)
          sel = tprsm_pkg::TPRSM_PIN_R;
        else if (code == tprsm_pkg::RT_CODE_V)
          sel = tprsm_pkg::TPRSM_PIN_V;
      end
      tprsm_pkg::CH_T0CH5:
      begin
        if (r[tprsm_pkg::RT_T0CH5_BIT])
          sel = tprsm_pkg::TPRSM_PIN_V;
      end
      tprsm_pkg::CH_T0CH4:
      begin
        if (r[tprsm_pkg::RT_T0CH4_BIT])
          sel = tprsm_pkg::TPRSM_PIN_V;
      end
      tprsm_pkg::CH_T1CH7:
      begin
        if (r[tprsm_pkg::RT_T1CH7_BIT])
          sel = tprsm_pkg::TPRSM_PIN_R;
      end
      default:
      begin
        if (r[tprsm_pkg::RT_T1CH6_BIT])
          sel = tprsm_pkg::TPRSM_PIN_R;
      end
    endcase
    return sel;
  endfunction

  // Data bit as software reads it
  function automatic logic [7:0] portSReadValue(input logic [7:0] data, input logic [7:0] dir,
                                                input logic [7:0] pins);
    return (data & dir) | (pins & ~dir);
  endfunction

  // Routing register
  always_ff @(posedge clk)
  begin
    if (reset)
      timerChannelRouting <= tprsm_pkg::RESET_ROUTING;
    else if (busWrite && busAddr == tprsm_pkg::OFS_ROUTING)
      timerChannelRouting <= busWriteData;
  end

  // Port S data register
  always_ff @(posedge clk)
  begin
    if (reset)
      portSPinData <= tprsm_pkg::RESET_PS_DATA;
    else if (busWrite && busAddr == tprsm_pkg::OFS_PS_DATA)
      portSPinData <= busWriteData;
  end

  // Port S direction register
  always_ff @(posedge clk)
  begin
    if (reset)
      portSDirection <= tprsm_pkg::RESET_PS_DIR;
    else if (busWrite && busAddr == tprsm_pkg::OFS_PS_DIR)
      portSDirection <= busWriteData;
  end

  always_comb
  begin
    if (busAddr == tprsm_pkg::OFS_ROUTING)
      next_busReadData = timerChannelRouting;
    else if (busAddr == tprsm_pkg::OFS_PS_DATA)
      next_busReadData = portSReadValue(portSPinData, portSDirection, portSIn);
    else if (busAddr == tprsm_pkg::OFS_PS_DIR)
      next_busReadData = portSDirection;
    else
      next_busReadData = tprsm_pkg::UNMAPPED_READ;
  end

  // Read data stand for one cycle only
  always_ff @(posedge clk)
  begin
    if (reset)
      busReadData <= tprsm_pkg::UNMAPPED_READ;
    else if (busRead)
      busReadData <= next_busReadData;
    else
      busReadData <= tprsm_pkg::UNMAPPED_READ;
  end

  // Routing is combinational from the register, so a write acts from the next edge
  always_comb
  begin
    for (int ch = 0; ch < tprsm_pkg::CH_NUM; ch++)
      chanSel[ch] = routeSel(ch, timerChannelRouting);
  end

  always_comb
  begin
    portTTimerOut = 8'h00;
    portTTimerOe = 8'h00;
    portTTimerOwned = 8'h00;
    portRTimerOut = 4'h0;
    portRTimerOe = 4'h0;
    portRTimerOwned = 4'h0;
    portVTimerOut = 8'h00;
    portVTimerOe = 8'h00;
    portVTimerOwned = 8'h00;
    timerCaptureIn = '0;
    for (int ch = 0; ch < tprsm_pkg::CH_NUM; ch++)
    begin
      case (chanSel[ch])
        tprsm_pkg::TPRSM_PIN_R:
        begin
          portRTimerOut[tprsm_pkg::CH_R_PIN[ch]] = timerChannel[ch].compareValue;
          portRTimerOe[tprsm_pkg::CH_R_PIN[ch]] = timerChannel[ch].compareEnable;
          portRTimerOwned[tprsm_pkg::CH_R_PIN[ch]] = 1'b1;
          timerCaptureIn[ch] = portRIn[tprsm_pkg::CH_R_PIN[ch]];
        end
        tprsm_pkg::TPRSM_PIN_V:
        begin
          portVTimerOut[tprsm_pkg::CH_V_PIN[ch]] = timerChannel[ch].compareValue;
          portVTimerOe[tprsm_pkg::CH_V_PIN[ch]] = timerChannel[ch].compareEnable;
          portVTimerOwned[tprsm_pkg::CH_V_PIN[ch]] = 1'b1;
          timerCaptureIn[ch] = portVIn[tprsm_pkg::CH_V_PIN[ch]];
        end
        default:
        begin
          portTTimerOut[tprsm_pkg::CH_T_PIN[ch]] = timerChannel[ch].compareValue;
          portTTimerOe[tprsm_pkg::CH_T_PIN[ch]] = timerChannel[ch].compareEnable;
          portTTimerOwned[tprsm_pkg::CH_T_PIN[ch]] = 1'b1;
          timerCaptureIn[ch] = portTIn[tprsm_pkg::CH_T_PIN[ch]];
        end
      endcase
    end
  end

  // Two-wire pins are open drain: drive low only, never high
  always_comb
  begin
    for (int p = 0; p < 8; p++)
    begin
      pinOwn[p] = 3'h0;
      pinDrive[p] = '0;
    end
    pinOwn[tprsm_pkg::PS_SS] = {spiEnable, twoWireEnable, pwmEnable[3]};
    pinDrive[tprsm_pkg::PS_SS] = {spiSs, {1'b0, twoWireSdaLow}, {pwmOut[3], 1'b1}};
    pinOwn[tprsm_pkg::PS_SCK] = {spiEnable, pwmEnable[2], 1'b0};
    pinDrive[tprsm_pkg::PS_SCK] = {spiSck, {pwmOut[2], 1'b1}, 2'h0};
    pinOwn[tprsm_pkg::PS_MOSI] = {spiEnable, pwmEnable[1], 1'b0};
    pinDrive[tprsm_pkg::PS_MOSI] = {spiMosi, {pwmOut[1], 1'b1}, 2'h0};
    pinOwn[tprsm_pkg::PS_MISO] = {spiEnable, twoWireEnable, pwmEnable[0]};
    pinDrive[tprsm_pkg::PS_MISO] = {spiMiso, {1'b0, twoWireSclLow}, {pwmOut[0], 1'b1}};
    pinOwn[tprsm_pkg::PS_CAN_TX] = {canEnable, 2'h0};
    pinDrive[tprsm_pkg::PS_CAN_TX] = {{canTx, 1'b1}, 4'h0};
    // Receive pin forced to input while CAN runs
    pinOwn[tprsm_pkg::PS_CAN_RX] = {canEnable, 2'h0};
    pinDrive[tprsm_pkg::PS_CAN_RX] = 6'h00;
    pinOwn[tprsm_pkg::PS_SER_TX] = {asyncSerialTxEnable, pwmEnable[7], 1'b0};
    pinDrive[tprsm_pkg::PS_SER_TX] = {{asyncSerialTx, 1'b1}, {pwmOut[7], 1'b1}, 2'h0};
    pinOwn[tprsm_pkg::PS_SER_RX] = {asyncSerialRxEnable, pwmEnable[6], 1'b0};
    pinDrive[tprsm_pkg::PS_SER_RX] = {2'h0, {pwmOut[6], 1'b1}, 2'h0};
  end

  for (genvar p = 0; p < 8; p++)
  begin : gPin
    tprsm_pin_cell uCell
    (
      .funcOwn(pinOwn[p]),
      .funcDrive(pinDrive[p]),
      .dataBit(portSPinData[p]),
      .dirBit(portSDirection[p]),
      .pinOut(portSOut[p]),
      .pinOe(portSOe[p]),
      .gpioOwned(portSGpio[p])
    );
  end

  // A peripheral that lost its pin sees an idle high level
  assign twoWireOwnsPins = twoWireEnable && !spiEnable;

  always_comb
  begin
    spiPinIn = spiEnable ? portSIn[tprsm_pkg::PS_SS:tprsm_pkg::PS_MISO]
      : {4{tprsm_pkg::IDLE_LEVEL}};
    twoWireSdaIn = twoWireOwnsPins ? portSIn[tprsm_pkg::PS_SS] : tprsm_pkg::IDLE_LEVEL;
    twoWireSclIn = twoWireOwnsPins ? portSIn[tprsm_pkg::PS_MISO] : tprsm_pkg::IDLE_LEVEL;
    canRx = canEnable ? portSIn[tprsm_pkg::PS_CAN_RX] : tprsm_pkg::IDLE_LEVEL;
    asyncSerialRx = asyncSerialRxEnable ? portSIn[tprsm_pkg::PS_SER_RX] : tprsm_pkg::IDLE_LEVEL;
  end

endmodule

// *** verif/tprsm_mux_props.sv ***
// Port-level assertions for the routing and port S mux
`timescale 1ns/100ps
module tprsm_mux_props
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] busAddr,
  input wire logic [7:0] busWriteData,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [7:0] busReadData,
  input wire logic [5:0] timerCaptureIn,
  input wire logic [7:0] portTIn,
  input wire logic [3:0] portRIn,
  input wire logic [7:0] portVIn,
  input wire logic spiEnable,
  input wire tprsm_pkg::tprsm_drive_s spiSs,
  input wire logic twoWireEnable,
  input wire logic twoWireSclLow,
  input wire logic canEnable,
  input wire logic canTx,
  input wire logic asyncSerialTxEnable,
  input wire logic asyncSerialTx,
  input wire logic [7:0] portSIn,
  input wire logic [7:0] portSOut,
  input wire logic [7:0] portSOe,
  input wire logic [7:0] portSGpio
);
  logic [7:0] rt;
  logic [7:0] dat;
  logic [7:0] dir;
  // Shadows of the registers, so pin relations can be stated
  always_ff @(posedge clk)
  begin
    if (reset)
      {rt, dat, dir} <= 24'h000000;
    else if (busWrite)
    begin
      if (busAddr == tprsm_pkg::OFS_ROUTING)
        rt <= busWriteData;
      if (busAddr == tprsm_pkg::OFS_PS_DATA)
        dat <= busWriteData;
      if (busAddr == tprsm_pkg::OFS_PS_DIR)
        dir <= busWriteData;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence rt_wr;
    busWrite && busAddr == tprsm_pkg::OFS_ROUTING;
  endsequence
  sequence rt_rd;
    busRead && busAddr == tprsm_pkg::OFS_ROUTING;
  endsequence
  route_t0ch7_a: assert property (timerCaptureIn[0] == (rt[7:6] == 2'h1 ? portRIn[1] :
    rt[7:6] == 2'h2 ? portVIn[6] : portTIn[7])) else $error("t0ch7 pin wrong");
  route_t0ch5_a: assert property (timerCaptureIn[2] == (rt[5] ? portVIn[2] : portTIn[5]))
    else $error("t0ch5 pin wrong");
  route_t0ch4_a: assert property (timerCaptureIn[3] == (rt[4] ? portVIn[0] : portTIn[4]))
    else $error("t0ch4 pin wrong");
  route_t0ch6_a: assert property (timerCaptureIn[1] == (rt[3:2] == 2'h1 ? portRIn[0] :
    rt[3:2] == 2'h2 ? portVIn[4] : portTIn[6])) else $error("t0ch6 pin wrong");
  route_t1ch7_a: assert property (timerCaptureIn[4] == (rt[1] ? portRIn[3] : portTIn[3]))
    else $error("t1ch7 pin wrong");
  route_t1ch6_a: assert property (timerCaptureIn[5] == (rt[0] ? portRIn[2] : portTIn[2]))
    else $error("t1ch6 pin wrong");
  gpio_drive_a: assert property (((portSGpio & dir & (portSOut ^ dat)) |
    (portSGpio & (portSOe ^ dir))) == 8'h00) else $error("free pin drive wrong");
  data_read_a: assert property (busRead && busAddr == tprsm_pkg::OFS_PS_DATA |=>
    busReadData == $past(dat & dir | portSIn & ~dir)) else $error("data read wrong");
  spi_select_a: assert property (spiEnable |-> portSOe[7] == spiSs.oe)
    else $error("select pin not owned");
  two_wire_scl_a: assert property (twoWireEnable && !spiEnable |->
    portSOe[4] == twoWireSclLow && !(portSOut[4] & portSOe[4])) else $error("scl pin wrong");
  can_pins_a: assert property (canEnable |-> portSOe[3] && portSOut[3] == canTx &&
    !portSOe[2]) else $error("can pins wrong");
  serial_tx_a: assert property (asyncSerialTxEnable |-> portSOe[1] &&
    portSOut[1] == asyncSerialTx) else $error("serial tx pin wrong");
  reg_readback_a: assert property (rt_wr ##1 rt_rd |=>
    busReadData == $past(busWriteData, 2)) else $error("routing readback wrong");
  read_idle_a: assert property (!$past(busRead) |-> busReadData == 8'h00)
    else $error("read data outside slot");
endmodule

bind tprsm_mux tprsm_mux_props i_props (.clk(clk), .reset(reset), .busAddr(busAddr),
  .busWriteData(busWriteData), .busWrite(busWrite), .busRead(busRead),
  .busReadData(busReadData), .timerCaptureIn(timerCaptureIn), .portTIn(portTIn),
  .portRIn(portRIn), .portVIn(portVIn), .spiEnable(spiEnable), .spiSs(spiSs),
  .twoWireEnable(twoWireEnable), .twoWireSclLow(twoWireSclLow), .canEnable(canEnable),
  .canTx(canTx), .asyncSerialTxEnable(asyncSerialTxEnable), .asyncSerialTx(asyncSerialTx),
  .portSIn(portSIn), .portSOut(portSOut), .portSOe(portSOe), .portSGpio(portSGpio));

// *** verif/tprsm_pad_model.sv ***
// Port S pads with an outside driver behind each pin
`timescale 1ns/100ps
module tprsm_pad_model
(
  input wire logic [7:0] portSOut,
  input wire logic [7:0] portSOe,
  input wire logic [7:0] ext,
  output logic [7:0] portSIn
);
  // Chip wins where it drives; outside driver is weak
  assign portSIn = portSOe & portSOut | ~portSOe & ext;
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the routing and port S mux
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] busAddr = 4'h0;
  logic [7:0] busWriteData = 8'h00;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic [7:0] busReadData, portTIn, portVIn, portTTimerOut, portTTimerOe, portTTimerOwned;
  logic [7:0] portVTimerOut, portVTimerOe, portVTimerOwned, pwmEnable, pwmOut;
  logic [7:0] portSIn, portSOut, portSOe, portSGpio, ext, x, y, d;
  logic [3:0] portRIn, portRTimerOut, portRTimerOe, portRTimerOwned, spiPinIn;
  logic [5:0] timerCaptureIn;
  logic spiEnable, twoWireEnable, twoWireSdaLow, twoWireSclLow, twoWireSdaIn, twoWireSclIn;
  logic canEnable, canTx, canRx, asyncSerialTxEnable, asyncSerialRxEnable, asyncSerialTx;
  logic asyncSerialRx;
  tprsm_pkg::tprsm_timer_s [5:0] timerChannel;
  tprsm_pkg::tprsm_drive_s spiSs, spiSck, spiMosi, spiMiso;
  logic [31:0] r = 32'h00bdd7b7;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  tprsm_mux i_dut
  (
    .clk(clk), .reset(reset), .busAddr(busAddr), .busWriteData(busWriteData),
    .busWrite(busWrite), .busRead(busRead), .busReadData(busReadData),
    .timerChannel(timerChannel), .timerCaptureIn(timerCaptureIn), .portTIn(portTIn),
    .portTTimerOut(portTTimerOut), .portTTimerOe(portTTimerOe),
    .portTTimerOwned(portTTimerOwned), .portRIn(portRIn), .portRTimerOut(portRTimerOut),
    .portRTimerOe(portRTimerOe), .portRTimerOwned(portRTimerOwned), .portVIn(portVIn),
    .portVTimerOut(portVTimerOut), .portVTimerOe(portVTimerOe),
    .portVTimerOwned(portVTimerOwned), .spiEnable(spiEnable), .spiSs(spiSs),
    .spiSck(spiSck), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiPinIn(spiPinIn),
    .twoWireEnable(twoWireEnable), .twoWireSdaLow(twoWireSdaLow),
    .twoWireSclLow(twoWireSclLow), .twoWireSdaIn(twoWireSdaIn), .twoWireSclIn(twoWireSclIn),
    .pwmEnable(pwmEnable), .pwmOut(pwmOut), .canEnable(canEnable), .canTx(canTx),
    .canRx(canRx), .asyncSerialTxEnable(asyncSerialTxEnable),
    .asyncSerialRxEnable(asyncSerialRxEnable), .asyncSerialTx(asyncSerialTx),
    .asyncSerialRx(asyncSerialRx), .portSIn(portSIn), .portSOut(portSOut),
    .portSOe(portSOe), .portSGpio(portSGpio)
  );
  tprsm_pad_model i_pad (.portSOut(portSOut), .portSOe(portSOe), .ext(ext), .portSIn(portSIn));
  always #12.5 clk = ~clk;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    for (int i = 0; i < 32; i++)
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  function automatic logic [5:0] capt(logic [7:0] t);
    logic [5:0] c;
    c[0] = t[7:6] == 2'h1 ? portRIn[1] : t[7:6] == 2'h2 ? portVIn[6] : portTIn[7];
    c[1] = t[3:2] == 2'h1 ? portRIn[0] : t[3:2] == 2'h2 ? portVIn[4] : portTIn[6];
    c[2] = t[5] ? portVIn[2] : portTIn[5];
    c[3] = t[4] ? portVIn[0] : portTIn[4];
    c[4] = t[1] ? portRIn[3] : portTIn[3];
    c[5] = t[0] ? portRIn[2] : portTIn[2];
    return c;
  endfunction
  // Later lines override earlier ones: highest priority last
  function automatic logic [15:0] expS(logic [7:0] o, logic [7:0] e);
    if (pwmEnable[3]) {e[7], o[7]} = {1'b1, pwmOut[3]};
    if (twoWireEnable) {e[7], o[7]} = {twoWireSdaLow, 1'b0};
    if (spiEnable) {o[7], e[7]} = spiSs;
    if (pwmEnable[2]) {e[6], o[6]} = {1'b1, pwmOut[2]};
    if (spiEnable) {o[6], e[6]} = spiSck;
    if (pwmEnable[1]) {e[5], o[5]} = {1'b1, pwmOut[1]};
    if (spiEnable) {o[5], e[5]} = spiMosi;
    if (pwmEnable[0]) {e[4], o[4]} = {1'b1, pwmOut[0]};
    if (twoWireEnable) {e[4], o[4]} = {twoWireSclLow, 1'b0};
    if (spiEnable) {o[4], e[4]} = spiMiso;
    if (canEnable) {e[3], o[3], e[2]} = {1'b1, canTx, 1'b0};
    if (pwmEnable[7]) {e[1], o[1]} = {1'b1, pwmOut[7]};
    if (asyncSerialTxEnable) {e[1], o[1]} = {1'b1, asyncSerialTx};
    if (pwmEnable[6]) {e[0], o[0]} = {1'b1, pwmOut[6]};
    if (asyncSerialRxEnable) e[0] = 1'b0;
    return {e, o & e};
  endfunction
  // Timer drive per pin, vector {T7..T0, ..R0, V7..V0}: owned, value, enable
  function automatic logic [59:0] expT(logic [7:0] t);
    logic [19:0] own, val, oe;
    int q [6];
    q[0] = t[7:6] == 2'h1 ? 9 : t[7:6] == 2'h2 ? 6 : 19;
    q[1] = t[3:2] == 2'h1 ? 8 : t[3:2] == 2'h2 ? 4 : 18;
    q[2] = t[5] ? 2 : 17;
    q[3] = t[4] ? 0 : 16;
    q[4] = t[1] ? 11 : 15;
    q[5] = t[0] ? 10 : 14;
    {own, val, oe} = 60'h0;
    for (int c = 0; c < 6; c++)
      {own[q[c]], val[q[c]], oe[q[c]]} = {1'b1, timerChannel[c]};
    return {own, val, oe};
  endfunction
  task automatic chk(logic [63:0] g, logic [63:0] e);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bus tasks start and end at a rising edge, so they chain back to back
  task automatic wr(logic [3:0] a, logic [7:0] v, logic more);
    {busWrite, busAddr, busWriteData} <= {1'b1, a, v};
    @(posedge clk);
    // Strobe stays up when another write follows at once
    if (!more)
      busWrite <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] v);
    {busRead, busAddr} <= {1'b1, a};
    @(posedge clk);
    busRead <= 1'b0;
    #1;
    v = busReadData;
    @(posedge clk);
  endtask
  task automatic drv(logic off);
    r = lfsr(r);
    {timerChannel, portTIn, portRIn, portVIn} <= r;
    r = lfsr(r);
    {spiSs, spiSck, spiMosi, spiMiso, twoWireSdaLow, twoWireSclLow, pwmOut, canTx,
      asyncSerialTx, ext} <= r[27:0];
    r = lfsr(r);
    {spiEnable, twoWireEnable, pwmEnable, canEnable, asyncSerialTxEnable,
      asyncSerialRxEnable} <= off ? 13'h0000 : r[12:0];
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    drv(1'b1);
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    for (int a = 0; a < 4; a++)
    begin
      rd(a == 3 ? 4'hf : a[3:0], d);
      // Data reads the pins while every direction bit is clear
      chk(d, a == 1 ? portSIn : 8'h00);
    end
    for (int i = 0; i < 24; i++)
    begin
      r = lfsr(r);
      x = i < 4 ? {4{i[1:0]}} : r[7:0];
      drv(1'b0);
      wr(tprsm_pkg::OFS_ROUTING, x, 1'b0);
      #1;
      chk(capt(x), timerCaptureIn);
      chk({portTTimerOwned, portRTimerOwned, portVTimerOwned,
        portTTimerOut, portRTimerOut, portVTimerOut, portTTimerOe, portRTimerOe, portVTimerOe},
        expT(x));
      @(posedge clk);
      wr(4'he, ~x, 1'b0);
      rd(tprsm_pkg::OFS_ROUTING, d);
      chk(d, x);
      // Read right behind the write must see the new value
      y = ~x;
      wr(tprsm_pkg::OFS_ROUTING, y, 1'b0);
      rd(tprsm_pkg::OFS_ROUTING, d);
      chk(d, y);
    end
    for (int i = 0; i < 40; i++)
    begin
      r = lfsr(r);
      {x, y} = r[15:0];
      wr(tprsm_pkg::OFS_PS_DATA, x, 1'b1);
      wr(tprsm_pkg::OFS_PS_DIR, y, 1'b0);
      rd(tprsm_pkg::OFS_PS_DIR, d);
      chk(d, y);
      drv(i < 8);
      #1;
      chk({portSOe, portSOut & portSOe}, expS(x, y));
      d = ~{pwmEnable[3] | twoWireEnable | spiEnable, pwmEnable[2] | spiEnable,
        pwmEnable[1] | spiEnable, pwmEnable[0] | twoWireEnable | spiEnable, {2{canEnable}},
        pwmEnable[7] | asyncSerialTxEnable, pwmEnable[6] | asyncSerialRxEnable};
      chk(portSGpio, d);
      chk({canRx, asyncSerialRx, spiPinIn, twoWireSdaIn, twoWireSclIn},
        {canEnable ? portSIn[2] : 1'b1, asyncSerialRxEnable ? portSIn[0] : 1'b1,
        spiEnable ? portSIn[7:4] : 4'hf,
        twoWireEnable && !spiEnable ? {portSIn[7], portSIn[4]} : 2'h3});
      @(posedge clk);
      rd(tprsm_pkg::OFS_PS_DATA, d);
      chk(d, x & y | portSIn & ~y);
    end
    end_sim();
  end
endmodule
